/* inc/regmap_if.sv */
// Command port between the host controller and the regulator register bank.
// Assumes both ends share sys_clk_i; the alert pad is open drain, resolved here.
`timescale 1ns/1ps
interface regmap_if;
   logic        req;       // One-cycle command strobe
   logic [7:0]  code;
   logic        wr;
   logic [15:0] wdata;
   logic        ack;       // One-cycle answer
   logic        invalid;   // With ack: command refused
   logic [15:0] rdata;
   logic        alert_n_o; // Device pad output
   logic        alert_n_oe;
   logic        alert_pad_n;
   // Open drain: low only while driven
   assign alert_pad_n = alert_n_oe ? alert_n_o : 1'b1;
   modport host   (output req, code, wr, wdata, input ack, invalid, rdata, alert_pad_n);
   modport device (input req, code, wr, wdata, output ack, invalid, rdata,
                   alert_n_o, alert_n_oe);
endinterface : regmap_if

/* inc/regmap_pkg.sv */
// Package for the regulator command map, upper range, and its host controller.
// Assumes one 40 MHz clock shared by both ends and an asynchronous active-high reset.
package regmap_pkg;
   // Command codes
   localparam logic [7:0] CMD_STORE_ALL      = 8'h15;
   localparam logic [7:0] CMD_RESTORE_ALL    = 8'h16;
   localparam logic [7:0] CMD_TON_MAX_RESP   = 8'h63;
   localparam logic [7:0] CMD_OFF_DELAY      = 8'h64;
   localparam logic [7:0] CMD_OFF_FALL       = 8'h65;
   localparam logic [7:0] CMD_STAT_BYTE      = 8'h78;
   localparam logic [7:0] CMD_STAT_WORD      = 8'h79;
   localparam logic [7:0] CMD_STAT_VOUT      = 8'h7a;
   localparam logic [7:0] CMD_STAT_IOUT      = 8'h7b;
   localparam logic [7:0] CMD_STAT_INPUT     = 8'h7c;
   localparam logic [7:0] CMD_STAT_TEMP      = 8'h7d;
   localparam logic [7:0] CMD_STAT_COMM      = 8'h7e;
   localparam logic [7:0] CMD_VENDOR_STATUS  = 8'h80;
   localparam logic [7:0] CMD_RD_VIN         = 8'h88;
   localparam logic [7:0] CMD_RD_IIN         = 8'h89;
   localparam logic [7:0] CMD_RD_VOUT        = 8'h8b;
   localparam logic [7:0] CMD_RD_IOUT        = 8'h8c;
   localparam logic [7:0] CMD_RD_TEMP        = 8'h8d;
   localparam logic [7:0] CMD_RD_FREQ        = 8'h95;
   localparam logic [7:0] CMD_PROTO_REV      = 8'h98;
   localparam logic [7:0] CMD_VENDOR_ID      = 8'h99;
   localparam logic [7:0] CMD_VENDOR_MODEL   = 8'h9a;
   localparam logic [7:0] CMD_VENDOR_REV     = 8'h9b;
   localparam logic [7:0] CMD_VENDOR_SERIAL  = 8'h9e;
   localparam logic [7:0] CMD_VOUT_MIN       = 8'ha4;
   localparam logic [7:0] CMD_VOUT_MAX       = 8'ha5;
   localparam logic [7:0] CMD_CHIP_ID        = 8'had;
   localparam logic [7:0] CMD_CHIP_REV       = 8'hae;
   localparam logic [7:0] CMD_AVG_OC_RESP    = 8'hc4;
   localparam logic [7:0] CMD_AVG_OC_LIMIT   = 8'hc5;
   localparam logic [7:0] CMD_PCT_LIMITS     = 8'hc6;
   localparam logic [7:0] CMD_PGOOD_LEVELS   = 8'hc7;
   localparam logic [7:0] CMD_MODE_SETTINGS  = 8'hc8;
   localparam logic [7:0] CMD_BASE_ADDR      = 8'hc9;
   localparam logic [7:0] CMD_VENDOR_WORD    = 8'hca;
   // Reset values
   localparam logic [7:0]  RST_TON_MAX_RESP  = 8'h80;
   localparam logic [15:0] RST_OFF_DELAY     = 16'h0000;
   localparam logic [15:0] RST_OFF_FALL      = 16'h0005;
   localparam logic [7:0]  RST_PROTO_REV     = 8'h33;
   localparam logic [15:0] RST_VOUT_MIN      = 16'h0100;
   localparam logic [15:0] RST_VOUT_MAX      = 16'h0b01;
   localparam logic [7:0]  RST_AVG_OC_RESP   = 8'h80;
   localparam logic [15:0] RST_AVG_OC_LIMIT  = 16'he340;
   localparam logic [15:0] RST_PCT_LIMITS    = 16'h06e0;
   localparam logic [7:0]  RST_PGOOD_LEVELS  = 8'h19;
   localparam logic [7:0]  RST_MODE_SETTINGS = 8'ha0;
   localparam logic [6:0]  RST_BASE_ADDR     = 7'h10;
   // Identity words: arbitrary neutral values
   localparam logic [15:0] ID_WORD_DEFAULT   = 16'h5a01;
   localparam logic [15:0] ID_VENDOR_WORD    = 16'h1234;
   localparam logic [7:0]  ID_LOW_BYTE       = 8'h01;
   // Mode-settings fields
   localparam int MODE_SENSE_MSB     = 7;
   localparam int MODE_SENSE_LSB     = 4;
   localparam int MODE_LS_AT_OVW_BIT = 1;
   localparam int MODE_VSEL_EN_BIT   = 0;
   // Vendor status field
   localparam int VSTAT_NV_FAULT_BIT = 1;
   // Host AXI register offsets
   localparam logic [7:0] AX_CMD      = 8'h00; // [7:0] code, [8] write, [9] force data low byte 01h, [10] go
   localparam logic [7:0] AX_WDATA    = 8'h04;
   localparam logic [7:0] AX_RDATA    = 8'h08;
   localparam logic [7:0] AX_CTRL     = 8'h0c; // [0] regulation enable
   localparam logic [7:0] AX_IRQ_STAT = 8'h10; // [0] done [1] invalid [2] nv fault
   localparam logic [7:0] AX_IRQ_MASK = 8'h14;
   localparam logic [7:0] AX_STATE    = 8'h18; // [0] busy [1] alert seen [2] reg en
   localparam logic [1:0] AXI_OKAY    = 2'b00;
   localparam logic [1:0] AXI_SLVERR  = 2'b10;
   localparam int IRQ_W = 3;
endpackage : regmap_pkg

/* logic/regmap_host.sv */
// Host controller: takes commands over AXI4-Lite and runs them on the command port.
// Assumes the register bank answers with ack one cycle after req, on sys_clk_i.
`timescale 1ns/1ps
module regmap_host
   import regmap_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   regmap_if.host           bus,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq_o
);
   import regmap_pkg::*;

   typedef struct packed {
      logic             awr, wr_ok, bv, rv;
      logic [7:0]       awaddr;
      logic [31:0]      wdata;
      logic [1:0]       bresp, rresp;
      logic [31:0]      rdata;
      logic [10:0]      cmd;
      logic [15:0]      wreg, rreg;
      logic             reg_en, busy, req, alert_s1, alert_s2, irq;
      logic [IRQ_W-1:0] stat, mask;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   always_comb begin
      logic [IRQ_W-1:0] ev;
      ev = '0;
      st_nxt = st_r;
      st_nxt.req = 1'b0;
      st_nxt.alert_s1 = ~bus.alert_pad_n;
      st_nxt.alert_s2 = st_r.alert_s1;
      // Command port answer
      if (bus.ack) begin
         st_nxt.busy = 1'b0;
         st_nxt.rreg = bus.rdata;
         ev[0] = 1'b1;
         ev[1] = bus.invalid;
      end
      ev[2] = st_r.alert_s2;
      // Capture write address and data in either order
      if (s_axi_awvalid && !st_r.awr && !st_r.bv) begin
         st_nxt.awr = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.wr_ok && !st_r.bv) begin
         st_nxt.wr_ok = 1'b1;
         st_nxt.wdata = s_axi_wdata;
      end
      if (st_r.awr && st_r.wr_ok) begin
         st_nxt.awr = 1'b0;
         st_nxt.wr_ok = 1'b0;
         st_nxt.bv = 1'b1;
         st_nxt.bresp = AXI_OKAY;
         unique case (st_r.awaddr)
            AX_CMD: begin
               st_nxt.cmd = st_r.wdata[10:0];
               if (st_r.wdata[10] && !st_r.busy) begin
                  st_nxt.busy = 1'b1;
                  st_nxt.req = 1'b1;
               end
            end
            AX_WDATA:    st_nxt.wreg = st_r.wdata[15:0];
            AX_CTRL:     st_nxt.reg_en = st_r.wdata[0];
            AX_IRQ_STAT: st_nxt.stat = st_r.stat & ~st_r.wdata[IRQ_W-1:0];
            AX_IRQ_MASK: st_nxt.mask = st_r.wdata[IRQ_W-1:0];
            default:     st_nxt.bresp = AXI_SLVERR;
         endcase
      end
      // Set wins over clear
      st_nxt.stat = st_nxt.stat | ev;
      if (st_r.bv && s_axi_bready) st_nxt.bv = 1'b0;
      if (s_axi_arvalid && !st_r.rv) begin
         st_nxt.rv = 1'b1;
         st_nxt.rresp = AXI_OKAY;
         unique case (s_axi_araddr)
            AX_CMD:      st_nxt.rdata = {21'h000000, st_r.cmd};
            AX_WDATA:    st_nxt.rdata = {16'h0000, st_r.wreg};
            AX_RDATA:    st_nxt.rdata = {16'h0000, st_r.rreg};
            AX_CTRL:     st_nxt.rdata = {31'h00000000, st_r.reg_en};
            AX_IRQ_STAT: st_nxt.rdata = {29'h00000000, st_r.stat};
            AX_IRQ_MASK: st_nxt.rdata = {29'h00000000, st_r.mask};
            AX_STATE:    st_nxt.rdata = {29'h00000000, st_r.reg_en, st_r.alert_s2, st_r.busy};
            default: begin
               st_nxt.rdata = 32'h00000000;
               st_nxt.rresp = AXI_SLVERR;
            end
         endcase
      end else if (st_r.rv && s_axi_rready) begin
         st_nxt.rv = 1'b0;
      end
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Low byte of write data forced to 01h on the way out when command bit 9 is set
   assign bus.req   = st_r.req;
   assign bus.code  = st_r.cmd[7:0];
   assign bus.wr    = st_r.cmd[8];
   assign bus.wdata = st_r.cmd[9] ? {st_r.wreg[15:8], ID_LOW_BYTE} : st_r.wreg;
   assign s_axi_awready = ~st_r.awr & ~st_r.bv;
   assign s_axi_wready  = ~st_r.wr_ok & ~st_r.bv;
   assign s_axi_bvalid  = st_r.bv;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = ~st_r.rv;
   assign s_axi_rvalid  = st_r.rv;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign irq_o         = st_r.irq;
endmodule : regmap_host

/* logic/regulator_command_map_upper.sv */
// What this block does
// - Base-address register sets bus address, reset 10h
// - Compare averaged current against average limit
// - Identity block words always have low byte 01h
// - Mode settings enable voltage-select pin, reset A0h
// - Mode bit keeps low-side switch at overvoltage warning
// - Mode bits 7:4 program monitor sense resistance
// - Sixteen-bit vendor identity word, nonvolatile backed
// - Host disables regulation during configuration writes (here reg_en is only a readable AX_CTRL bit that gates nothing)
// - Host disables regulation during store or restore (here reg_en is only a readable AX_CTRL bit that gates nothing)
// - Nonvolatile check failure pulls alert, sets status
// - Store-all saves, restore-all reloads configuration
// Register bank of the regulator, commands 63h..CAh plus store/restore.
// Assumes telemetry, status and the nonvolatile check come from analog logic on sys_clk_i.
`timescale 1ns/1ps
module regulator_command_map_upper
   import regmap_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   regmap_if.device         bus,
   input  wire logic        nv_check_fail_i,    // Startup nonvolatile check result
   input  wire logic [15:0] avg_current_i,      // Averaged output current, limit format
   input  wire logic [7:0]  status_i [7],       // Byte, vout, iout, input, temp, comm, vendor
   input  wire logic [15:0] status_word_i,
   input  wire logic [15:0] telemetry_i [6],    // vin, iin, vout, iout, temp, freq
   input  wire logic        voltage_select_pin_i,
   output logic             avg_overcurrent_o,
   output logic [6:0]       bus_address_o,
   output logic             voltage_select_en_o,
   output logic             low_side_switch_on_ovw_o,
   output logic [3:0]       monitor_sense_resistance_o,
   output logic             voltage_select_o
);
   import regmap_pkg::*;

   typedef struct packed {
      logic [7:0]  ton_resp;
      logic [15:0] off_delay;
      logic [15:0] off_fall;
      logic [15:0] id_model;
      logic [15:0] id_vendor;
      logic [15:0] id_serial;
      logic [7:0]  avg_resp;
      logic [15:0] avg_limit;
      logic [15:0] pct_limits;
      logic [7:0]  pgood;
      logic [7:0]  mode;
      logic [6:0]  base;
      logic [15:0] vendor_word;
   } cfg_t;

   typedef struct packed {
      cfg_t        cfg;
      cfg_t        nv;      // Nonvolatile image
      logic        nv_fault;
      logic        ack;
      logic        invalid;
      logic [15:0] rdata;
      logic        alert;
      logic        ovc;
      logic [1:0]  pin_s;   // Voltage-select pin synchroniser
      logic        vsel;
   } state_t;

   localparam cfg_t CFG_DEFAULT = '{
      ton_resp: RST_TON_MAX_RESP,
      off_delay: RST_OFF_DELAY,
      off_fall: RST_OFF_FALL,
      id_model: ID_WORD_DEFAULT,
      id_vendor: ID_WORD_DEFAULT,
      id_serial: ID_WORD_DEFAULT,
      avg_resp: RST_AVG_OC_RESP,
      avg_limit: RST_AVG_OC_LIMIT,
      pct_limits: RST_PCT_LIMITS,
      pgood: RST_PGOOD_LEVELS,
      mode: RST_MODE_SETTINGS,
      base: RST_BASE_ADDR,
      vendor_word: ID_VENDOR_WORD
   };

   state_t st_r;
   state_t st_nxt;

   // Read-only status, telemetry, revision, chip-ID and output-voltage range codes
   function automatic logic is_read_only(input logic [7:0] c);
      case (c)
         CMD_STAT_BYTE, CMD_STAT_WORD, CMD_STAT_VOUT, CMD_STAT_IOUT, CMD_STAT_INPUT,
         CMD_STAT_TEMP, CMD_STAT_COMM, CMD_VENDOR_STATUS, CMD_RD_VIN, CMD_RD_IIN,
         CMD_RD_VOUT, CMD_RD_IOUT, CMD_RD_TEMP, CMD_RD_FREQ, CMD_PROTO_REV,
         CMD_VENDOR_REV, CMD_VOUT_MIN, CMD_VOUT_MAX, CMD_CHIP_ID, CMD_CHIP_REV:
            return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_read_only

   // Command decode and register update
   always_comb begin
      logic hit;
      logic [15:0] rd;
      hit = 1'b1;
      rd = 16'h0000;
      st_nxt = st_r;
      st_nxt.ack = bus.req;
      st_nxt.invalid = 1'b0;
      st_nxt.ovc = avg_current_i > st_r.cfg.avg_limit;
      // Pin passes two flops; only the second is read
      st_nxt.pin_s = {st_r.pin_s[0], voltage_select_pin_i};
      st_nxt.vsel = st_r.cfg.mode[MODE_VSEL_EN_BIT] & st_r.pin_s[1];
      // Startup check failure latches until reset
      if (nv_check_fail_i) begin
         st_nxt.nv_fault = 1'b1;
         st_nxt.alert = 1'b1;
      end
      unique case (bus.code)
         CMD_TON_MAX_RESP:  rd = {8'h00, st_r.cfg.ton_resp};
         CMD_OFF_DELAY:     rd = st_r.cfg.off_delay;
         CMD_OFF_FALL:      rd = st_r.cfg.off_fall;
         CMD_STAT_BYTE:     rd = {8'h00, status_i[0]};
         CMD_STAT_WORD:     rd = status_word_i;
         CMD_STAT_VOUT:     rd = {8'h00, status_i[1]};
         CMD_STAT_IOUT:     rd = {8'h00, status_i[2]};
         CMD_STAT_INPUT:    rd = {8'h00, status_i[3]};
         CMD_STAT_TEMP:     rd = {8'h00, status_i[4]};
         CMD_STAT_COMM:     rd = {8'h00, status_i[5]};
         CMD_VENDOR_STATUS: begin
            rd = {8'h00, status_i[6]};
            rd[VSTAT_NV_FAULT_BIT] = st_r.nv_fault;
         end
         CMD_RD_VIN:        rd = telemetry_i[0];
         CMD_RD_IIN:        rd = telemetry_i[1];
         CMD_RD_VOUT:       rd = telemetry_i[2];
         CMD_RD_IOUT:       rd = telemetry_i[3];
         CMD_RD_TEMP:       rd = telemetry_i[4];
         CMD_RD_FREQ:       rd = telemetry_i[5];
         CMD_PROTO_REV:     rd = {8'h00, RST_PROTO_REV};
         CMD_VENDOR_ID:     rd = {st_r.cfg.id_vendor[15:8], ID_LOW_BYTE};
         CMD_VENDOR_MODEL:  rd = {st_r.cfg.id_model[15:8], ID_LOW_BYTE};
         CMD_VENDOR_REV:    rd = {ID_WORD_DEFAULT[15:8], ID_LOW_BYTE};
         CMD_VENDOR_SERIAL: rd = {st_r.cfg.id_serial[15:8], ID_LOW_BYTE};
         CMD_VOUT_MIN:      rd = RST_VOUT_MIN;
         CMD_VOUT_MAX:      rd = RST_VOUT_MAX;
         CMD_CHIP_ID:       rd = {ID_WORD_DEFAULT[15:8], ID_LOW_BYTE};
         CMD_CHIP_REV:      rd = {ID_WORD_DEFAULT[15:8], ID_LOW_BYTE};
         CMD_AVG_OC_RESP:   rd = {8'h00, st_r.cfg.avg_resp};
         CMD_AVG_OC_LIMIT:  rd = st_r.cfg.avg_limit;
         CMD_PCT_LIMITS:    rd = st_r.cfg.pct_limits;
         CMD_PGOOD_LEVELS:  rd = {8'h00, st_r.cfg.pgood};
         CMD_MODE_SETTINGS: rd = {8'h00, st_r.cfg.mode};
         CMD_BASE_ADDR:     rd = {9'h000, st_r.cfg.base};
         CMD_VENDOR_WORD:   rd = st_r.cfg.vendor_word;
         CMD_STORE_ALL, CMD_RESTORE_ALL: rd = 16'h0000;
         default:           hit = 1'b0;
      endcase
      if (bus.req) begin
         st_nxt.rdata = bus.wr ? 16'h0000 : rd;
         if (!hit || (bus.wr && is_read_only(bus.code))
             || (!bus.wr && (bus.code == CMD_STORE_ALL || bus.code == CMD_RESTORE_ALL))) begin
            st_nxt.invalid = 1'b1;
         end else if (bus.wr) begin
            unique case (bus.code)
               CMD_STORE_ALL:     st_nxt.nv = st_r.cfg;
               CMD_RESTORE_ALL:   st_nxt.cfg = st_r.nv;
               CMD_TON_MAX_RESP:  st_nxt.cfg.ton_resp = bus.wdata[7:0];
               CMD_OFF_DELAY:     st_nxt.cfg.off_delay = bus.wdata;
               CMD_OFF_FALL:      st_nxt.cfg.off_fall = bus.wdata;
               CMD_VENDOR_ID:     st_nxt.cfg.id_vendor = {bus.wdata[15:8], ID_LOW_BYTE};
               CMD_VENDOR_MODEL:  st_nxt.cfg.id_model = {bus.wdata[15:8], ID_LOW_BYTE};
               CMD_VENDOR_SERIAL: st_nxt.cfg.id_serial = {bus.wdata[15:8], ID_LOW_BYTE};
               CMD_AVG_OC_RESP:   st_nxt.cfg.avg_resp = bus.wdata[7:0];
               CMD_AVG_OC_LIMIT:  st_nxt.cfg.avg_limit = bus.wdata;
               CMD_PCT_LIMITS:    st_nxt.cfg.pct_limits = bus.wdata;
               CMD_PGOOD_LEVELS:  st_nxt.cfg.pgood = bus.wdata[7:0];
               CMD_MODE_SETTINGS: st_nxt.cfg.mode = bus.wdata[7:0];
               CMD_BASE_ADDR:     st_nxt.cfg.base = bus.wdata[6:0];
               CMD_VENDOR_WORD:   st_nxt.cfg.vendor_word = bus.wdata;
               default:           st_nxt.invalid = 1'b0;
            endcase
         end
      end
   end

   // State register; defaults after reset, nonvolatile image seeded with them
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '{cfg: CFG_DEFAULT, nv: CFG_DEFAULT, nv_fault: 1'b0, ack: 1'b0,
                   invalid: 1'b0, rdata: 16'h0000, alert: 1'b0, ovc: 1'b0,
                   pin_s: 2'b00, vsel: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state flops, except alert_n_o, which is tied low
   assign bus.ack                    = st_r.ack;
   assign bus.invalid                = st_r.invalid;
   assign bus.rdata                  = st_r.rdata;
   assign bus.alert_n_o              = 1'b0;
   assign bus.alert_n_oe             = st_r.alert;
   assign avg_overcurrent_o          = st_r.ovc;
   assign bus_address_o              = st_r.cfg.base;
   assign voltage_select_en_o        = st_r.cfg.mode[MODE_VSEL_EN_BIT];
   assign low_side_switch_on_ovw_o   = st_r.cfg.mode[MODE_LS_AT_OVW_BIT];
   assign monitor_sense_resistance_o = st_r.cfg.mode[MODE_SENSE_MSB:MODE_SENSE_LSB];
   assign voltage_select_o           = st_r.vsel;
endmodule : regulator_command_map_upper

/* tb/regmap_sva.sv */
// Checker for the command port between host controller and register bank.
// Assumes the signals of one regmap_if, all sampled on sys_clk_i.
`timescale 1ns/1ps
module regmap_sva
   import regmap_pkg::*;
(
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        req,
   input wire logic [7:0]  code,
   input wire logic        wr,
   input wire logic [15:0] wdata,
   input wire logic        ack,
   input wire logic        invalid,
   input wire logic [15:0] rdata,
   input wire logic        alert_n_o,
   input wire logic        alert_n_oe
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [7:0] mode_r;
   logic [7:0] mode_nv_r;
   wire ro_c = code inside {[8'h78:8'h7e], 8'h80, 8'h88, 8'h89, [8'h8b:8'h8d], 8'h95};
   wire id_c = code inside {8'h99, 8'h9a, 8'h9b, 8'h9e, 8'had, 8'hae};
   wire nv_c = code inside {CMD_STORE_ALL, CMD_RESTORE_ALL};
   sequence s_id_read; req && !wr && id_c; endsequence
   sequence s_mode_read; req && !wr && code == CMD_MODE_SETTINGS; endsequence
   // Shadow of the mode byte and its stored image
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_r    <= RST_MODE_SETTINGS;
         mode_nv_r <= RST_MODE_SETTINGS;
      end else if (req && wr) begin
         if (code == CMD_MODE_SETTINGS) mode_r <= wdata[7:0];
         if (code == CMD_STORE_ALL) mode_nv_r <= mode_r;
         if (code == CMD_RESTORE_ALL) mode_r <= mode_nv_r;
      end
   end
   ack_follows_req_a: assert property (req |=> ack) else $error("ack missing");
   ack_has_cause_a: assert property (ack |-> $past(req)) else $error("ack without request");
   invalid_with_ack_a: assert property (invalid |-> ack) else $error("invalid outside ack");
   ro_write_refused_a: assert property (req && wr && ro_c |=> invalid)
      else $error("read-only write accepted");
   id_low_byte_a: assert property (s_id_read |=> !invalid && rdata[7:0] == ID_LOW_BYTE)
      else $error("identity low byte wrong");
   nv_cmd_taken_a: assert property (req && wr && nv_c |=> !invalid)
      else $error("store or restore refused");
   mode_readback_a: assert property (s_mode_read |=> rdata[7:0] == mode_r)
      else $error("mode byte readback wrong");
   rdata_holds_a: assert property (!ack |-> $stable(rdata)) else $error("rdata moved");
   alert_low_only_a: assert property (alert_n_oe |=> alert_n_oe && !alert_n_o)
      else $error("alert pad released or driven high");
endmodule : regmap_sva

/* tb/regulator_command_map_upper_tb_top.sv */
// Testbench: host controller and register bank joined by regmap_if, driven over AXI4-Lite.
// Assumes one 40 MHz clock and the host register layout of regmap_pkg.
`timescale 1ns/1ps
module regulator_command_map_upper_tb_top;
   import regmap_pkg::*;
   logic        sys_clk_i, sys_rst_i, nv_fail, vsel_pin, oc, vsel_en, ls_on, vsel, irq;
   logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, cmd_stat, cmd_data, tmp;
   logic [1:0]  bresp, rresp;
   logic [15:0] avg_cur, stat_word;
   logic [7:0]  stat_v [7];
   logic [15:0] tele_v [6];
   logic [6:0]  bus_addr;
   logic [3:0]  sense;
   logic [7:0]  def_c [12] = '{8'h63, 8'h64, 8'h65, 8'h98, 8'ha4, 8'ha5, 8'hc4, 8'hc5,
      8'hc6, 8'hc7, 8'hc8, 8'hc9};
   logic [15:0] def_v [12] = '{16'h80, 16'h0, 16'h5, 16'h33, 16'h100, 16'hb01, 16'h80,
      16'he340, 16'h6e0, 16'h19, 16'ha0, 16'h10};
   logic [7:0]  ro_c [14] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80,
      8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h95};
   logic [7:0]  id_c [6] = '{8'h99, 8'h9a, 8'h9b, 8'h9e, 8'had, 8'hae};
   int          num_errors = 0, check_count = 0, cycles = 0;
   regmap_if bus_if ();
   regulator_command_map_upper u_regulator_command_map_upper (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .bus(bus_if), .nv_check_fail_i(nv_fail), .avg_current_i(avg_cur),
      .status_i(stat_v), .status_word_i(stat_word), .telemetry_i(tele_v),
      .voltage_select_pin_i(vsel_pin), .avg_overcurrent_o(oc), .bus_address_o(bus_addr),
      .voltage_select_en_o(vsel_en), .low_side_switch_on_ovw_o(ls_on),
      .monitor_sense_resistance_o(sense), .voltage_select_o(vsel));
   regmap_host u_regmap_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq_o(irq));
   regmap_sva u_regmap_sva (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req(bus_if.req),
      .code(bus_if.code), .wr(bus_if.wr), .wdata(bus_if.wdata), .ack(bus_if.ack),
      .invalid(bus_if.invalid), .rdata(bus_if.rdata), .alert_n_o(bus_if.alert_n_o),
      .alert_n_oe(bus_if.alert_n_oe));
   // Clock and hang guard
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // AXI write: aw and w offered together, each dropped once taken
   task automatic ax_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      tmp = {30'h0, bresp};
   endtask : ax_wr
   task automatic ax_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      tmp = {30'h0, rresp};
   endtask : ax_rd
   // One command; checks refusal and the read word
   task automatic run(input logic [7:0] c, input logic w, input logic [15:0] d,
                      input logic [15:0] e, input logic inv);
      ax_wr(AX_IRQ_STAT, 32'h3);
      ax_wr(AX_WDATA, {16'h0, d});
      ax_wr(AX_CMD, {21'h0, 1'b1, c == CMD_VENDOR_ID, w, c});
      cmd_stat = 32'h0;
      while (!cmd_stat[0]) ax_rd(AX_IRQ_STAT, cmd_stat);
      ax_rd(AX_RDATA, cmd_data);
      chk({31'h0, cmd_stat[1]}, {31'h0, inv});
      if (!w && !inv) chk({16'h0, cmd_data[15:0]}, {16'h0, e});
   endtask : run
   // Main sequence
   initial begin
      {nv_fail, awvalid, wvalid, bready, arvalid, rready} = '0;
      vsel_pin = 1'b1;
      {awaddr, araddr, wdata, avg_cur, stat_word} = '0;
      for (int k = 0; k < 7; k++) stat_v[k] = 8'h0;
      for (int k = 0; k < 6; k++) tele_v[k] = 16'h1000 + 16'(k);
      sys_rst_i = 1'b1;
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 12; i++) run(def_c[i], 1'b0, 16'h0, def_v[i], 1'b0);
      chk({25'h0, bus_addr}, 32'h10);
      chk({27'h0, sense, vsel}, 32'h14);
      for (int i = 0; i < 6; i++) begin
         run(id_c[i], 1'b0, 16'h0, ID_WORD_DEFAULT, 1'b0);
         chk({24'h0, cmd_data[7:0]}, 32'h01);
      end
      for (int i = 0; i < 14; i++) run(ro_c[i], 1'b1, 16'hffff, 16'h0, 1'b1);
      for (int i = 8; i < 14; i++) run(ro_c[i], 1'b0, 16'h0, tele_v[i-8], 1'b0);
      run(8'h70, 1'b0, 16'h0, 16'h0, 1'b1);
      run(CMD_STORE_ALL, 1'b0, 16'h0, 16'h0, 1'b1);
      ax_rd(8'h1c, cmd_data);
      chk(tmp, {30'h0, AXI_SLVERR});
      ax_wr(8'h1c, 32'h0);
      chk(tmp, {30'h0, AXI_SLVERR});
      ax_wr(AX_CTRL, 32'h0);
      run(CMD_VENDOR_ID, 1'b1, 16'h7755, 16'h0, 1'b0);
      run(CMD_VENDOR_ID, 1'b0, 16'h0, 16'h7701, 1'b0);
      run(CMD_VENDOR_WORD, 1'b1, 16'hbeef, 16'h0, 1'b0);
      run(CMD_VENDOR_WORD, 1'b0, 16'h0, 16'hbeef, 1'b0);
      run(CMD_MODE_SETTINGS, 1'b1, 16'h53, 16'h0, 1'b0);
      chk({25'h0, sense, ls_on, vsel_en, vsel}, {25'h0, 4'h5, 3'b111});
      run(CMD_BASE_ADDR, 1'b1, 16'h2a, 16'h0, 1'b0);
      chk({25'h0, bus_addr}, 32'h2a);
      run(CMD_STORE_ALL, 1'b1, 16'h0, 16'h0, 1'b0);
      run(CMD_MODE_SETTINGS, 1'b1, 16'ha0, 16'h0, 1'b0);
      run(CMD_RESTORE_ALL, 1'b1, 16'h0, 16'h0, 1'b0);
      run(CMD_MODE_SETTINGS, 1'b0, 16'h0, 16'h53, 1'b0);
      ax_wr(AX_CTRL, 32'h1);
      chk({31'h0, irq}, 32'h0);
      ax_wr(AX_IRQ_MASK, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      chk({31'h0, irq}, 32'h1);
      ax_wr(AX_IRQ_STAT, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      chk({31'h0, irq}, 32'h0);
      avg_cur <= 16'he340;
      repeat (3) @(posedge sys_clk_i);
      chk({31'h0, oc}, 32'h0);
      avg_cur <= 16'he341;
      repeat (3) @(posedge sys_clk_i);
      chk({31'h0, oc}, 32'h1);
      nv_fail <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      chk({31'h0, bus_if.alert_pad_n}, 32'h0);
      run(CMD_VENDOR_STATUS, 1'b0, 16'h0, 16'h2, 1'b0);
      chk({31'h0, cmd_data[VSTAT_NV_FAULT_BIT]}, 32'h1);
      ax_wr(AX_IRQ_MASK, 32'h4);
      chk({31'h0, irq}, 32'h1);
      tally_and_finish();
   end
endmodule : regulator_command_map_upper_tb_top
